// ### lpc_pkg.sv
// Package of constants, register map and mode encoding for the low-power clock and watchdog block.
package lpc_pkg;

    // ************************************************************
    // Register map and fields
    // ************************************************************
    localparam int         TB_WIDTH     = 18;
    localparam logic [7:0] ADR_CLKSEL   = 8'h00;
    localparam logic [7:0] ADR_WDOG     = 8'h04;
    localparam logic [7:0] ADR_TBASE    = 8'h08;
    localparam logic [7:0] ADR_MODE     = 8'h0C;
    localparam logic [7:0] ADR_STAT     = 8'h10;
    localparam int         CS_MAIN_BIT  = 0;
    localparam int         CS_MULT_LO   = 1;
    localparam int         CS_WAIT_LO   = 3;
    localparam int         CS_INTM_BIT  = 5;
    localparam logic [5:0] CLKSEL_RST   = 6'h01;
    localparam int         WD_EN_BIT    = 0;
    localparam int         WD_CLR_BIT   = 1;
    localparam int         WD_CAUSE_BIT = 2;
    localparam int         TB_IE_BIT    = 0;
    localparam int         TB_SEL_LO    = 1;
    localparam int         TB_IF_BIT    = 3;
    localparam int         TB_CLR_BIT   = 4;
    localparam logic [2:0] CMD_SLEEP    = 3'h1;
    localparam logic [2:0] CMD_TIMER    = 3'h2;
    localparam logic [2:0] CMD_STOP     = 3'h3;

    // ************************************************************
    // Timing
    // ************************************************************
    localparam int         STAB_TAP [4] = '{10, 13, 15, 17};
    localparam int         INT_TAP  [4] = '{11, 13, 15, 17};
    localparam logic [2:0] WD_RST_CYCLES = 3'h4;
    localparam logic [1:0] INTM_RATIO    = 2'h3;

    typedef enum logic [2:0] {
        ST_PLL_RUN, ST_PLL_SLEEP, ST_TIMER, ST_MAIN_RUN,
        ST_MAIN_SLEEP, ST_STOP, ST_HW_STANDBY, ST_OSC_WAIT
    } lpc_state_e;

    function automatic logic [TB_WIDTH-1:0] lpc_tap_mask(input int tap);
        lpc_tap_mask = TB_WIDTH'((1 << tap) - 1);
    endfunction : lpc_tap_mask

endpackage : lpc_pkg

// ### lpc_tb_if.sv
// Interface carrying the timebase count and carry between the controller and its counters.
`timescale 1ns/1ps
interface lpc_tb_if;
    logic        run;
    logic        clear;
    logic [17:0] count;
    logic        carry;
    modport tb  (input run, input clear, output count, output carry);
    modport ctl (output run, output clear, input count, input carry);
    modport wd  (input carry);
endinterface : lpc_tb_if

// ### lpc_timebase.sv
// The free-running timebase counter on the main oscillator clock.
`timescale 1ns/1ps
module lpc_timebase (
    input  logic   clk_i,
    input  logic   rst_i,
    lpc_tb_if.tb   tb
);
    import lpc_pkg::*;

    // ************************************************************
    // Counter
    // ************************************************************
    // Main clock only.
    always_ff @(posedge clk_i) begin
        if (rst_i || tb.clear) begin
            tb.count <= '0;
        end else if (tb.run) begin
            tb.count <= tb.count + 18'h0_0001;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tb.carry <= 1'h0;
        end else begin
            tb.carry <= tb.run && !tb.clear && (&tb.count);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    tb_counts_a: assert property (@(posedge clk_i) disable iff (rst_i)
        tb.run && !tb.clear |=> tb.count == $past(tb.count) + 18'h0_0001)
        else $error("Timebase did not advance while running.");

endmodule : lpc_timebase

// ### lpc_watchdog.sv
// Two-bit watchdog counter clocked by the timebase carry.
`timescale 1ns/1ps
module lpc_watchdog (
    input  logic       clk_i,
    input  logic       rst_i,
    lpc_tb_if.wd       tb,
    input  logic       enable_i,
    input  logic       clear_i,
    output logic [1:0] count_o,
    output logic       overflow_o
);
    import lpc_pkg::*;

    // ************************************************************
    // Counter
    // ************************************************************
    // Advance on carry.
    always_ff @(posedge clk_i) begin
        if (rst_i || clear_i || !enable_i) begin
            count_o <= 2'h0;
        end else if (tb.carry) begin
            count_o <= count_o + 2'h1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            overflow_o <= 1'h0;
        end else begin
            overflow_o <= enable_i && !clear_i && tb.carry && (count_o == 2'h3);
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    wd_advance_a: assert property (@(posedge clk_i) disable iff (rst_i)
        enable_i && !clear_i && tb.carry |=> count_o == $past(count_o) + 2'h1)
        else $error("Watchdog counter missed a timebase carry.");

endmodule : lpc_watchdog

// ### lpc_clock_ctrl.sv
// Top of the clock, low-power mode, timebase and watchdog control block.
//
// Behaviour
// - Two-bit watchdog counts timebase eighteen-bit carries.
// - Timebase runs from main clock in every mode except stop and standby.
// - Timebase raises periodic interval interrupt request.
// - Seven modes; all but PLL run are low-power.
// - Main modes stop PLL, use clock halves.
// - Sleep modes stop only the CPU clock.
// - Timer mode clocks only the timebase.
// - Stop and standby halt oscillator, keep state.
// - Intermittent mode slows CPU during accesses.
// - Two-bit field selects PLL ratio one-four.
// - Two-bit field selects oscillator stabilisation wait.
`timescale 1ns/1ps
module lpc_clock_ctrl (
    input  logic        clk_i,
    input  logic        rst_i,
    input  logic [7:0]  wb_adr_i,
    input  logic [31:0] wb_dat_i,
    input  logic [3:0]  wb_sel_i,
    input  logic        wb_we_i,
    input  logic        wb_cyc_i,
    input  logic        wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic        wb_ack_o,
    input  logic        wake_i,
    input  logic        hw_standby_n_i,
    input  logic        bus_access_i,
    output logic        mclk_en_o,
    output logic        cpu_clk_en_o,
    output logic        periph_clk_en_o,
    output logic        pll_run_o,
    output logic        osc_run_o,
    output logic [2:0]  pll_ratio_o,
    output logic        low_power_o,
    output logic        tb_irq_o,
    output logic        wd_reset_o
);
    import lpc_pkg::*;

    lpc_tb_if   tbus ();
    lpc_state_e state;
    lpc_state_e next_state;
    lpc_state_e run_state;
    logic [5:0] clksel;
    logic       wd_en;
    logic       wd_clr;
    logic       wd_cause;
    logic [1:0] wd_count;
    logic       wd_ovf;
    logic [2:0] wd_hold;
    logic       tb_ie;
    logic [1:0] tb_sel;
    logic       tb_flag;
    logic       tb_clr_wr;
    logic       tb_tick;
    logic       stab_tick;
    logic       cmd_go;
    logic [2:0] cmd;
    logic [2:0] wake_sync;
    logic [1:0] hst_sync;
    logic       wake_s;
    logic       div_ph;
    logic [1:0] intm_cnt;
    logic       next_mclk;
    logic       wr;
    logic       rd_go;

    assign wake_s = wake_sync[1] && !wake_sync[2];

    // ************************************************************
    // Pin synchronisers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wake_sync <= 3'h0;
            hst_sync  <= 2'h3;
        end else begin
            wake_sync <= {wake_sync[1:0], wake_i};
            hst_sync  <= {hst_sync[0], hw_standby_n_i};
        end
    end

    // ************************************************************
    // Wishbone slave
    // ************************************************************
    assign wr    = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_sel_i[0];
    assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'h0;
        end else begin
            wb_ack_o <= rd_go;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (rd_go && !wb_we_i) begin
            if (wb_adr_i == ADR_CLKSEL) begin
                wb_dat_o <= {26'h000_0000, clksel};
            end else if (wb_adr_i == ADR_WDOG) begin
                wb_dat_o <= {27'h000_0000, wd_count, wd_cause, 1'h0, wd_en};
            end else if (wb_adr_i == ADR_TBASE) begin
                wb_dat_o <= {28'h000_0000, tb_flag, tb_sel, tb_ie};
            end else if (wb_adr_i == ADR_MODE) begin
                wb_dat_o <= {29'h000_0000, cmd};
            end else if (wb_adr_i == ADR_STAT) begin
                wb_dat_o <= {27'h000_0000, state == ST_OSC_WAIT, low_power_o, state};
            end else begin
                wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // ************************************************************
    // Control registers
    // ************************************************************
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            clksel <= CLKSEL_RST;
        end else if (wr && wb_adr_i == ADR_CLKSEL) begin
            clksel <= wb_dat_i[5:0];
        end
    end

    // The enable bit is write-once so runaway code cannot switch the watchdog off.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_en  <= 1'h0;
            wd_clr <= 1'h0;
        end else begin
            wd_clr <= wr && wb_adr_i == ADR_WDOG && wb_dat_i[WD_CLR_BIT];
            if (wr && wb_adr_i == ADR_WDOG && wb_dat_i[WD_EN_BIT]) begin
                wd_en <= 1'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_cause <= 1'h0;
        end else if (wd_ovf) begin
            wd_cause <= 1'h1;
        end else if (wr && wb_adr_i == ADR_WDOG && wb_dat_i[WD_CAUSE_BIT]) begin
            wd_cause <= 1'h0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tb_ie     <= 1'h0;
            tb_sel    <= 2'h0;
            tb_clr_wr <= 1'h0;
        end else begin
            tb_clr_wr <= wr && wb_adr_i == ADR_TBASE && wb_dat_i[TB_CLR_BIT];
            if (wr && wb_adr_i == ADR_TBASE) begin
                tb_ie  <= wb_dat_i[TB_IE_BIT];
                tb_sel <= wb_dat_i[TB_SEL_LO +: 2];
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_go <= 1'h0;
            cmd    <= 3'h0;
        end else begin
            cmd_go <= wr && wb_adr_i == ADR_MODE;
            if (wr && wb_adr_i == ADR_MODE) begin
                cmd <= wb_dat_i[2:0];
            end
        end
    end

    // ************************************************************
    // Timebase and watchdog
    // ************************************************************
    // Runs whatever the clock select.
    assign tbus.run   = state != ST_STOP && state != ST_HW_STANDBY;
    assign tbus.clear = tb_clr_wr || (next_state == ST_OSC_WAIT && state != ST_OSC_WAIT);
    assign tb_tick    = tbus.run && ((tbus.count & lpc_tap_mask(INT_TAP[tb_sel])) == lpc_tap_mask(INT_TAP[tb_sel]));
    assign stab_tick  = (tbus.count & lpc_tap_mask(STAB_TAP[clksel[CS_WAIT_LO +: 2]]))
                        == lpc_tap_mask(STAB_TAP[clksel[CS_WAIT_LO +: 2]]);

    lpc_timebase u_tb (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .tb    (tbus.tb)
    );

    lpc_watchdog u_wd (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .tb         (tbus.wd),
        .enable_i   (wd_en),
        .clear_i    (wd_clr),
        .count_o    (wd_count),
        .overflow_o (wd_ovf)
    );

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tb_flag  <= 1'h0;
            tb_irq_o <= 1'h0;
        end else begin
            if (tb_tick) begin
                tb_flag <= 1'h1;
            end else if (wr && wb_adr_i == ADR_TBASE && wb_dat_i[TB_IF_BIT]) begin
                tb_flag <= 1'h0;
            end
            tb_irq_o <= tb_flag && tb_ie;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wd_hold    <= 3'h0;
            wd_reset_o <= 1'h0;
        end else begin
            if (wd_ovf) begin
                wd_hold <= WD_RST_CYCLES;
            end else if (wd_hold != 3'h0) begin
                wd_hold <= wd_hold - 3'h1;
            end
            wd_reset_o <= wd_ovf || wd_hold > 3'h1;
        end
    end

    // ************************************************************
    // Mode state machine
    // ************************************************************
    assign run_state = clksel[CS_MAIN_BIT] ? ST_MAIN_RUN : ST_PLL_RUN;

    always_comb begin
        next_state = state;
        if (!hst_sync[1]) begin
            next_state = ST_HW_STANDBY;
        end else begin
            case (state)
                ST_PLL_RUN, ST_MAIN_RUN: begin
                    if (cmd_go && cmd == CMD_SLEEP) begin
                        next_state = (state == ST_PLL_RUN) ? ST_PLL_SLEEP : ST_MAIN_SLEEP;
                    end else if (cmd_go && cmd == CMD_TIMER) begin
                        next_state = ST_TIMER;
                    end else if (cmd_go && cmd == CMD_STOP) begin
                        next_state = ST_STOP;
                    end else begin
                        next_state = run_state;
                    end
                end
                ST_PLL_SLEEP, ST_MAIN_SLEEP, ST_TIMER: begin
                    if (wake_s) begin
                        next_state = run_state;
                    end
                end
                ST_STOP: begin
                    if (wake_s) begin
                        next_state = ST_OSC_WAIT;
                    end
                end
                ST_HW_STANDBY: begin
                    next_state = ST_OSC_WAIT;
                end
                ST_OSC_WAIT: begin
                    if (stab_tick) begin
                        next_state = run_state;
                    end
                end
                default: begin
                    next_state = run_state;
                end
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= ST_MAIN_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ************************************************************
    // Clock enables
    // ************************************************************
    // Halved main clock.
    assign next_mclk = clksel[CS_MAIN_BIT] ? div_ph : 1'h1;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_ph   <= 1'h0;
            intm_cnt <= 2'h0;
        end else begin
            div_ph <= !div_ph;
            if (!bus_access_i) begin
                intm_cnt <= 2'h0;
            end else if (next_mclk) begin
                intm_cnt <= (intm_cnt == INTM_RATIO) ? 2'h0 : intm_cnt + 2'h1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mclk_en_o       <= 1'h0;
            cpu_clk_en_o    <= 1'h0;
            periph_clk_en_o <= 1'h0;
            pll_run_o       <= 1'h0;
            osc_run_o       <= 1'h1;
            pll_ratio_o     <= 3'h1;
            low_power_o     <= 1'h1;
        end else begin
            mclk_en_o       <= next_mclk;
            cpu_clk_en_o    <= (state == ST_PLL_RUN || state == ST_MAIN_RUN) && next_mclk
                               && (!(clksel[CS_INTM_BIT] && bus_access_i) || intm_cnt == 2'h0);
            periph_clk_en_o <= next_mclk && (state == ST_PLL_RUN || state == ST_PLL_SLEEP
                               || state == ST_MAIN_RUN || state == ST_MAIN_SLEEP);
            pll_run_o       <= state == ST_PLL_RUN || state == ST_PLL_SLEEP;
            osc_run_o       <= tbus.run;
            pll_ratio_o     <= {1'h0, clksel[CS_MULT_LO +: 2]} + 3'h1;
            low_power_o     <= state != ST_PLL_RUN;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    stop_osc_off_a: assert property (
        state == ST_STOP || state == ST_HW_STANDBY |=> !osc_run_o && !pll_run_o)
        else $error("Oscillator running in stop or standby.");
    main_pll_off_a: assert property (
        state == ST_MAIN_RUN || state == ST_MAIN_SLEEP |=> !pll_run_o)
        else $error("PLL running in a main clock mode.");
    main_half_rate_a: assert property (
        clksel[CS_MAIN_BIT] ##1 clksel[CS_MAIN_BIT] |=> mclk_en_o != $past(mclk_en_o))
        else $error("Main clock enable is not half rate.");
    sleep_cpu_off_a: assert property (
        state == ST_PLL_SLEEP || state == ST_MAIN_SLEEP |=> !cpu_clk_en_o && periph_clk_en_o == $past(next_mclk))
        else $error("Sleep gating wrong.");
    timer_only_tb_a: assert property (
        state == ST_TIMER |-> tbus.run ##1 (!cpu_clk_en_o && !periph_clk_en_o))
        else $error("Timer mode clocks wrong.");
    wait_cpu_off_a: assert property (
        state == ST_OSC_WAIT |=> !cpu_clk_en_o)
        else $error("CPU clocked during stabilisation wait.");
    wait_release_a: assert property (
        state == ST_OSC_WAIT && hst_sync[1] && stab_tick |=> state == $past(run_state))
        else $error("Stabilisation wait did not end on its tap.");
    wd_reset_len_a: assert property (
        wd_ovf |=> wd_reset_o [*4] ##1 !wd_reset_o)
        else $error("Watchdog reset pulse length wrong.");
    pll_ratio_a: assert property (
        1'h1 |=> pll_ratio_o == {1'h0, $past(clksel[CS_MULT_LO +: 2])} + 3'h1)
        else $error("PLL ratio does not follow its field.");
    low_power_a: assert property (
        1'h1 |=> low_power_o == ($past(state) != ST_PLL_RUN))
        else $error("Low-power status wrong.");
    intm_slow_a: assert property (
        clksel[CS_INTM_BIT] && bus_access_i && intm_cnt != 2'h0 |=> !cpu_clk_en_o)
        else $error("CPU clocked between intermittent slots.");
    irq_follow_a: assert property (
        tb_tick && tb_ie && hst_sync[1] |=> ##1 tb_irq_o)
        else $error("Interval request not raised.");

    stop_exit_c: cover property (state == ST_STOP ##[1:20] state == ST_OSC_WAIT);
    wd_fire_c: cover property (wd_ovf ##1 wd_reset_o);
    sleep_wake_c: cover property (state == ST_PLL_SLEEP ##[1:20] state == ST_PLL_RUN);

endmodule : lpc_clock_ctrl

// ### tb_low_power_clock_watchdog.sv
// Self-checking bench for the clock, low-power mode, timebase and watchdog block.
`timescale 1ns/1ps
module tb_low_power_clock_watchdog;
    import lpc_pkg::*;
    logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, wake_i, hw_standby_n_i, bus_access_i;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, q;
    logic [3:0]  wb_sel_i, sel_nx;
    logic        mclk_en_o, cpu_clk_en_o, periph_clk_en_o, pll_run_o, osc_run_o, low_power_o, tb_irq_o, wd_reset_o;
    logic [2:0]  pll_ratio_o;
    int          failures, n_compared, n_cpu, n_per, n_mc, c0, p0, m0, n;
    logic [5:0]  v;

    lpc_clock_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i),
        .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .wake_i(wake_i), .hw_standby_n_i(hw_standby_n_i), .bus_access_i(bus_access_i),
        .mclk_en_o(mclk_en_o), .cpu_clk_en_o(cpu_clk_en_o), .periph_clk_en_o(periph_clk_en_o),
        .pll_run_o(pll_run_o), .osc_run_o(osc_run_o), .pll_ratio_o(pll_ratio_o), .low_power_o(low_power_o),
        .tb_irq_o(tb_irq_o), .wd_reset_o(wd_reset_o));

    // ************************************************************
    // Clock, enable counters and shared tasks
    // ************************************************************
    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end

    // Counted on the falling edge so the registered enables are settled.
    always @(negedge clk_i) begin
        n_cpu += (cpu_clk_en_o === 1'b1);
        n_per += (periph_clk_en_o === 1'b1);
        n_mc  += (mclk_en_o === 1'b1);
    end

    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    function automatic logic [2:0] exp_ratio(input logic [5:0] s);
        exp_ratio = {1'b0, s[CS_MULT_LO +: 2]} + 3'h1;
    endfunction : exp_ratio

    function automatic int stab_cycles(input logic [5:0] s);
        stab_cycles = 1 << STAB_TAP[s[CS_WAIT_LO +: 2]];
    endfunction : stab_cycles

    // Only the bench watchdog ends a wait for the acknowledge.
    task automatic wb(input logic [7:0] a, input logic we, input logic [7:0] d);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= we;
        wb_sel_i <= sel_nx;
        wb_adr_i <= a;
        wb_dat_i <= {24'h00_0000, d};
        do begin
            @(posedge clk_i);
        end while (wb_ack_o !== 1'b1);
        q = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i  <= 1'b0;
    endtask : wb

    task automatic window(input int c);
        c0 = n_cpu;
        p0 = n_per;
        m0 = n_mc;
        repeat (c) @(posedge clk_i);
        c0 = n_cpu - c0;
        p0 = n_per - p0;
        m0 = n_mc - m0;
    endtask : window

    task automatic wake;
        wake_i <= 1'b1;
        repeat (3) @(posedge clk_i);
        wake_i <= 1'b0;
        repeat (6) @(posedge clk_i);
    endtask : wake

    // The stabilisation wait is the gap until the CPU enable returns.
    task automatic wait_cpu;
        n = 0;
        while (cpu_clk_en_o !== 1'b1 && n < 20000) begin
            @(posedge clk_i);
            n++;
        end
    endtask : wait_cpu

    task automatic close_out;
        if (failures == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : close_out

    initial begin
        repeat (40000) @(posedge clk_i);
        failures++;
        close_out();
    end

    // ************************************************************
    // Scenarios
    // ************************************************************
    initial begin
        {wb_cyc_i, wb_stb_i, wb_we_i, wake_i, bus_access_i} = '0;
        wb_adr_i = '0;
        wb_dat_i = '0;
        wb_sel_i = 4'h1;
        sel_nx = 4'h1;
        hw_standby_n_i = 1'b1;
        rst_i = 1'b1;
        void'($urandom(30547));
        repeat (11) @(posedge clk_i);
        @(negedge clk_i);
        check("reset_osc", osc_run_o, 1); // oscillator on
        check("reset_lp", low_power_o, 1); // main run
        check("reset_wdr", wd_reset_o, 0); // no reset
        @(posedge clk_i);
        rst_i <= 1'b0;
        wb(ADR_CLKSEL, 0, 0); check("clksel_rst", q, CLKSEL_RST); // reset value
        wb(ADR_STAT, 0, 0); check("state_rst", q[2:0], ST_MAIN_RUN); // start state
        wb(8'h14, 0, 0); check("unmapped", q, 0); // unmapped reads
        sel_nx = 4'h0;
        wb(ADR_CLKSEL, 1, 8'h3E);
        sel_nx = 4'h1;
        wb(ADR_CLKSEL, 0, 0); check("sel_off", q, CLKSEL_RST); // lane disabled
        wb(ADR_WDOG, 1, 8'h01);
        wb(ADR_WDOG, 1, 8'h02);
        wb(ADR_WDOG, 0, 0); check("wd_on", q, 1); // enabled, count zero
        check("wd_quiet", wd_reset_o, 0); // no overflow yet
        for (int i = 0; i < 8; i++) begin
            v = (i < 4) ? 6'((i << 1) | (i & 1)) : 6'($urandom);
            wb(ADR_CLKSEL, 1, {2'b00, v});
            repeat (2) @(posedge clk_i);
            check("ratio", pll_ratio_o, exp_ratio(v)); // ratio
            check("pll_run", pll_run_o, !v[CS_MAIN_BIT]); // stop pll
            check("low_pwr", low_power_o, v[CS_MAIN_BIT]); // low power
        end
        wb(ADR_CLKSEL, 1, 8'h01); window(40); check("mclk_main", m0, 20); // half rate
        wb(ADR_CLKSEL, 1, 8'h00); window(40); check("mclk_pll", m0, 40); // full rate
        wb(ADR_CLKSEL, 1, 8'h20);
        bus_access_i <= 1'b1;
        @(posedge clk_i);
        window(40); check("intm_slow", c0, 40 / (int'(INTM_RATIO) + 1)); // slowed cpu
        bus_access_i <= 1'b0;
        @(posedge clk_i);
        window(40); check("intm_full", c0, 40); // idle full speed
        wb(ADR_CLKSEL, 1, 8'h01);
        wb(ADR_MODE, 1, CMD_SLEEP);
        wb(ADR_STAT, 0, 0); check("sleep_st", q[2:0], ST_MAIN_SLEEP); // sleep entry
        window(20); check("sleep_cpu", c0, 0); // cpu stops
        check("sleep_per", p0, 10); // peripherals run
        wake(); wb(ADR_STAT, 0, 0); check("sleep_wake", q[2:0], ST_MAIN_RUN); // resume
        wb(ADR_TBASE, 1, 8'h19);
        n = 0;
        fork
            while (tb_irq_o !== 1'b1 && n < 4000) begin
                @(posedge clk_i);
                n++;
            end
            begin
                wb(ADR_MODE, 1, CMD_TIMER);
                wb(ADR_STAT, 0, 0); check("timer_st", q[2:0], ST_TIMER); // timer entry
                window(20); check("timer_clk", c0 + p0, 0); // others stopped
            end
        join
        check("irq_time", n >= (1 << INT_TAP[0]) && n <= (1 << INT_TAP[0]) + 8, 1); // interval period
        wake(); wb(ADR_STAT, 0, 0); check("timer_wake", q[2:0], ST_MAIN_RUN); // resume
        wb(ADR_TBASE, 1, 8'h09); repeat (3) @(posedge clk_i); check("irq_clr", tb_irq_o, 0); // flag clear
        wb(ADR_MODE, 1, CMD_STOP); repeat (3) @(posedge clk_i);
        check("stop_osc", osc_run_o, 0); // oscillator halted
        wb(ADR_STAT, 0, 0); check("stop_st", q[2:0], ST_STOP); // stop entry
        wb(ADR_CLKSEL, 0, 0); check("stop_keep", q, 1); // contents kept
        wake_i <= 1'b1;
        wait_cpu();
        wake_i <= 1'b0;
        check("wait_tap0", n >= stab_cycles(6'h01) && n <= stab_cycles(6'h01) + 8, 1); // short wait
        wb(ADR_CLKSEL, 1, 8'h09);
        hw_standby_n_i <= 1'b0; repeat (4) @(posedge clk_i);
        wb(ADR_STAT, 0, 0); check("stby_st", q[2:0], ST_HW_STANDBY); // standby entry
        check("stby_osc", osc_run_o, 0); // oscillator halted
        hw_standby_n_i <= 1'b1;
        wait_cpu(); check("wait_tap1", n >= stab_cycles(6'h09) && n <= stab_cycles(6'h09) + 8, 1); // long wait
        wb(ADR_STAT, 0, 0); check("stby_out", q[2:0], ST_MAIN_RUN); // back to run
        check("wd_end", wd_reset_o, 0); // no spurious reset
        close_out();
    end
endmodule : tb_low_power_clock_watchdog
